// ==== ipf_pkg.sv ====
// constants for the capture/compare interrupt priority word
package ipf_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] PRIO_WORD_OFS  = 12'h000;
   localparam logic [11:0] LEVEL_VIEW_OFS = 12'h004;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OC7_LSB = 12;
   localparam int OC6_LSB = 8;
   localparam int OC5_LSB = 4;
   localparam int IC6_LSB = 0;
   localparam int NUM_SRC = 4;
   // ----------------------------------------------------------------
   // values
   // ----------------------------------------------------------------
   localparam logic [2:0]  PRIO_RESET  = 3'h4;
   localparam logic [2:0]  PRIO_OFF    = 3'h0;
   localparam logic [2:0]  PRIO_MIN    = 3'h1;
   localparam logic [2:0]  PRIO_MAX    = 3'h7;
   localparam logic [15:0] IMPL_MASK   = 16'h7777;
   localparam logic [15:0] WORD_RESET  = 16'h4444;
   localparam logic [3:0]  EN_RESET    = 4'hF;
endpackage : ipf_pkg

// ==== ipf_prio.sv ====
// priority word register with apb access and per-source level outputs
// Overview of operation
// - field value 111 means level 7, the highest level.
// - field value 001 means level 1, lowest level still active.
// - field value 000 disables the source; it is never taken.
// - oc6_priority is read-write at bits 10 to 8.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ipf_prio (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // priority levels to arbitration
   output logic      [2:0]  oc7_priority,
   output logic      [2:0]  oc6_priority,
   output logic      [2:0]  oc5_priority,
   output logic      [2:0]  ic6_priority,
   // source enabled flags, ic6 oc5 oc6 oc7 in bits 0..3
   output logic      [3:0]  src_enabled
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // level 000 means the source is disabled
   function automatic logic active(input logic [2:0] lvl);
      return lvl != ipf_pkg::PRIO_OFF;
   endfunction

   function automatic logic [3:0] enables(input logic [15:0] w);
      return {active(w[ipf_pkg::OC7_LSB +: 3]), active(w[ipf_pkg::OC6_LSB +: 3]),
              active(w[ipf_pkg::OC5_LSB +: 3]), active(w[ipf_pkg::IC6_LSB +: 3])};
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [15:0] word_r, word_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [3:0]  en_r, en_nxt;

   logic setup;
   logic access;
   logic hit_word;
   logic hit_view;
   logic [15:0] wmask;

   assign setup    = psel && !penable;
   assign access   = psel && penable && pready_r;
   assign hit_word = (paddr == ipf_pkg::PRIO_WORD_OFS);
   assign hit_view = (paddr == ipf_pkg::LEVEL_VIEW_OFS);
   assign wmask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // ----------------------------------------------------------------
   // bus answer, next values
   // ----------------------------------------------------------------
   always_comb begin
      prdata_nxt  = prdata_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      // answer one cycle after setup, read data captured in setup
      if (setup) begin
         pready_nxt = 1'b1;
         if (hit_word) begin
            if (!pwrite) begin
               prdata_nxt = {16'h0000, word_r & ipf_pkg::IMPL_MASK};
            end
         end else if (hit_view) begin
            pslverr_nxt = pwrite;
            if (!pwrite) begin
               prdata_nxt = {28'h0000000, en_r};
            end
         end else begin
            pslverr_nxt = 1'b1;
            prdata_nxt  = 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // priority word, next values
   // ----------------------------------------------------------------
   always_comb begin
      word_nxt = word_r;
      // write lands at the access edge
      if (access && pwrite && hit_word) begin
         word_nxt = (word_r & ~wmask) | (pwdata[15:0] & wmask & ipf_pkg::IMPL_MASK);
      end
      en_nxt = enables(word_nxt);
   end

   // ----------------------------------------------------------------
   // bus answer registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // priority word registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         word_r <= ipf_pkg::WORD_RESET;
         en_r   <= ipf_pkg::EN_RESET;
      end else begin
         word_r <= word_nxt;
         en_r   <= en_nxt;
      end
   end

   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign pslverr      = pslverr_r;
   assign oc7_priority = word_r[ipf_pkg::OC7_LSB +: 3];
   assign oc6_priority = word_r[ipf_pkg::OC6_LSB +: 3];
   assign oc5_priority = word_r[ipf_pkg::OC5_LSB +: 3];
   assign ic6_priority = word_r[ipf_pkg::IC6_LSB +: 3];
   assign src_enabled  = en_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_MAX_LEVEL: assert property (@(posedge clk) disable iff (rst)
      (oc7_priority == ipf_pkg::PRIO_MAX) |-> src_enabled[3])
      else $error("level 7 source not enabled");

   AST_MIN_LEVEL: assert property (@(posedge clk) disable iff (rst)
      (ic6_priority == ipf_pkg::PRIO_MIN) |-> src_enabled[0])
      else $error("level 1 source not enabled");

   AST_OFF_LEVEL: assert property (@(posedge clk) disable iff (rst)
      (oc5_priority == ipf_pkg::PRIO_OFF) |-> !src_enabled[1])
      else $error("level 0 source still enabled");

   AST_OC6_WRITE: assert property (@(posedge clk) disable iff (rst)
      (access && pwrite && hit_word && pstrb[1]) |=> (oc6_priority == $past(pwdata[10:8])))
      else $error("oc6 field write lost");

   AST_GAPS_ZERO: assert property (@(posedge clk) disable iff (rst)
      (pready && !pslverr && $past(hit_word && !pwrite)) |-> (prdata[15] == 1'b0
         && prdata[11] == 1'b0 && prdata[7] == 1'b0 && prdata[3] == 1'b0))
      else $error("unused bit read nonzero");

   AST_RESET_VAL: assert property (@(posedge clk)
      $past(rst) |-> (word_r == ipf_pkg::WORD_RESET && pready == 1'b0))
      else $error("reset value wrong");

   AST_ONE_WAIT: assert property (@(posedge clk) disable iff (rst)
      setup |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   AST_HOLD: assert property (@(posedge clk) disable iff (rst)
      !(access && pwrite && hit_word) |=> $stable(oc6_priority))
      else $error("oc6 field changed without write");

   // ----------------------------------------------------------------
   // level meaning per source
   // ----------------------------------------------------------------
   AST_MAX_OC6: assert property (@(posedge clk) disable iff (rst)
      (oc6_priority == ipf_pkg::PRIO_MAX) |-> src_enabled[2])
      else $error("oc6 level 7 not enabled");

   AST_MAX_OC5: assert property (@(posedge clk) disable iff (rst)
      (oc5_priority == ipf_pkg::PRIO_MAX) |-> src_enabled[1])
      else $error("oc5 level 7 not enabled");

   AST_MAX_IC6: assert property (@(posedge clk) disable iff (rst)
      (ic6_priority == ipf_pkg::PRIO_MAX) |-> src_enabled[0])
      else $error("ic6 level 7 not enabled");

   AST_MIN_OC7: assert property (@(posedge clk) disable iff (rst)
      (oc7_priority == ipf_pkg::PRIO_MIN) |-> src_enabled[3])
      else $error("oc7 level 1 not enabled");

   AST_MIN_OC6: assert property (@(posedge clk) disable iff (rst)
      (oc6_priority == ipf_pkg::PRIO_MIN) |-> src_enabled[2])
      else $error("oc6 level 1 not enabled");

   AST_MIN_OC5: assert property (@(posedge clk) disable iff (rst)
      (oc5_priority == ipf_pkg::PRIO_MIN) |-> src_enabled[1])
      else $error("oc5 level 1 not enabled");

   AST_OFF_OC7: assert property (@(posedge clk) disable iff (rst)
      (oc7_priority == ipf_pkg::PRIO_OFF) |-> !src_enabled[3])
      else $error("oc7 level 0 still enabled");

   AST_OFF_OC6: assert property (@(posedge clk) disable iff (rst)
      (oc6_priority == ipf_pkg::PRIO_OFF) |-> !src_enabled[2])
      else $error("oc6 level 0 still enabled");

   AST_OFF_IC6: assert property (@(posedge clk) disable iff (rst)
      (ic6_priority == ipf_pkg::PRIO_OFF) |-> !src_enabled[0])
      else $error("ic6 level 0 still enabled");

   AST_ON_OC7: assert property (@(posedge clk) disable iff (rst)
      (oc7_priority != ipf_pkg::PRIO_OFF) |-> src_enabled[3])
      else $error("oc7 nonzero level disabled");

   AST_ON_OC6: assert property (@(posedge clk) disable iff (rst)
      (oc6_priority != ipf_pkg::PRIO_OFF) |-> src_enabled[2])
      else $error("oc6 nonzero level disabled");

   AST_ON_OC5: assert property (@(posedge clk) disable iff (rst)
      (oc5_priority != ipf_pkg::PRIO_OFF) |-> src_enabled[1])
      else $error("oc5 nonzero level disabled");

   AST_ON_IC6: assert property (@(posedge clk) disable iff (rst)
      (ic6_priority != ipf_pkg::PRIO_OFF) |-> src_enabled[0])
      else $error("ic6 nonzero level disabled");

   // ----------------------------------------------------------------
   // field writes and holds
   // ----------------------------------------------------------------
   AST_OC7_WRITE: assert property (@(posedge clk) disable iff (rst)
      (access && pwrite && hit_word && pstrb[1]) |=> (oc7_priority == $past(pwdata[14:12])))
      else $error("oc7 field write lost");

   AST_OC5_WRITE: assert property (@(posedge clk) disable iff (rst)
      (access && pwrite && hit_word && pstrb[0]) |=> (oc5_priority == $past(pwdata[6:4])))
      else $error("oc5 field write lost");

   AST_IC6_WRITE: assert property (@(posedge clk) disable iff (rst)
      (access && pwrite && hit_word && pstrb[0]) |=> (ic6_priority == $past(pwdata[2:0])))
      else $error("ic6 field write lost");

   AST_HOLD_OC7: assert property (@(posedge clk) disable iff (rst)
      !(access && pwrite && hit_word) |=> $stable(oc7_priority))
      else $error("oc7 field changed without write");

   AST_HOLD_OC5: assert property (@(posedge clk) disable iff (rst)
      !(access && pwrite && hit_word) |=> $stable(oc5_priority))
      else $error("oc5 field changed without write");

   AST_HOLD_IC6: assert property (@(posedge clk) disable iff (rst)
      !(access && pwrite && hit_word) |=> $stable(ic6_priority))
      else $error("ic6 field changed without write");

   AST_LANE_KEEP: assert property (@(posedge clk) disable iff (rst)
      (access && pwrite && hit_word && !pstrb[1]) |=> $stable(oc6_priority))
      else $error("oc6 field written without its lane");

   // ----------------------------------------------------------------
   // bus answers
   // ----------------------------------------------------------------
   AST_READ_WORD: assert property (@(posedge clk) disable iff (rst)
      (setup && hit_word && !pwrite) |=> (prdata == {16'h0000, 1'b0, $past(oc7_priority),
         1'b0, $past(oc6_priority), 1'b0, $past(oc5_priority), 1'b0, $past(ic6_priority)}))
      else $error("word read data wrong");

   AST_ERR_UNMAPPED: assert property (@(posedge clk) disable iff (rst)
      (setup && !hit_word && !hit_view) |=> (pready && pslverr && prdata == 32'h00000000))
      else $error("unmapped access not refused");

   AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (rst)
      pslverr |-> pready)
      else $error("error without ready");

endmodule : ipf_prio
`default_nettype wire

// ==== ipf_prio_tb.sv ====
// testbench for the capture/compare priority word
`timescale 1ns/100ps
`default_nettype none
module ipf_prio_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  oc7_priority;
   logic [2:0]  oc6_priority;
   logic [2:0]  oc5_priority;
   logic [2:0]  ic6_priority;
   logic [3:0]  src_enabled;
   logic [31:0] rd;
   logic        err;
   int          n_errors = 0;
   int          compares = 0;
   always #50 clk = ~clk;
   ipf_prio i_ipf_prio (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .oc7_priority(oc7_priority), .oc6_priority(oc6_priority),
      .oc5_priority(oc5_priority), .ic6_priority(ic6_priority), .src_enabled(src_enabled));
   // ----------------------------------------------------------------
   // apb master and compare
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] lv();
      return {16'h0000, src_enabled, oc7_priority, oc6_priority, oc5_priority, ic6_priority};
   endfunction
   task automatic finish_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h00004444); // reset word
      chk({31'h0, err}, 32'h0); // word read accepted
      chk(lv(), 32'h0000F924); // reset levels
      apb(1'b1, 12'h000, 32'hFFFFFFFF, 4'h3); chk(lv(), 32'h0000FFFF); // level 7
      apb(1'b0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h00007777); // gaps zero
      apb(1'b1, 12'h000, 32'h00000100, 4'h3); chk(lv(), 32'h00004040);
      apb(1'b0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h00000100); // field 10-8
      apb(1'b1, 12'h000, 32'h00007FFF, 4'h1); chk(lv(), 32'h0000707F); // lane 0 only
      apb(1'b1, 12'h004, 32'h0, 4'h3); chk({31'h0, err}, 32'h1); // read-only view
      apb(1'b0, 12'h008, 32'h0, 4'h0); chk({rd[30:0], err}, 32'h1); // unmapped
      apb(1'b0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h00000177); // word kept
      apb(1'b1, 12'h000, 32'h00000001, 4'h1); chk(lv(), 32'h00005041); // ic6 level 1
      apb(1'b0, 12'h004, 32'h0, 4'h0); chk(rd, 32'h00000005); // enable view
      chk({31'h0, err}, 32'h0); // view read accepted
      apb(1'b1, 12'h000, 32'h00001010, 4'h3); chk(lv(), 32'h0000A208);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h00004444); // reset again
      chk(lv(), 32'h0000F924); // levels after reset
      finish_test();
   end
   initial begin
      repeat (2000) @(posedge clk);
      n_errors++;
      finish_test();
   end
endmodule // ipf_prio_tb
`default_nettype wire
